// ==== rtl/dbm_pkg.sv ====
/*
 * Shared constants and types of the DMA bus mastership handshake.
 * Assumes one 50 MHz clock; pin levels are active low outside the block.
 */
package dbm_pkg;

    // ----------------------------------------------------------------
    // Timing counts, in clocks of i_clk, and the clock period in ns
    // ----------------------------------------------------------------
    localparam int FRONT_MIN_CLKS = 12;
    localparam int REARB_DELAY_CLKS = 3;
    localparam int REQ_MIN_CLKS = 2;
    localparam int CLK_PERIOD_NS = 20;

    // ----------------------------------------------------------------
    // Bus exception codes (after inversion of the pins)
    // ----------------------------------------------------------------
    localparam logic [2:0] BEC_NORMAL = 3'h0;
    localparam logic [2:0] BEC_HALT = 3'h1;
    localparam logic [2:0] BEC_RETRY = 3'h3;
    localparam logic [2:0] BEC_RELINQUISH = 3'h4;

    // ----------------------------------------------------------------
    // Synchronised bus handshake bundle, active high
    // ----------------------------------------------------------------
    typedef struct packed {
        logic bus_grant_in;
        logic grant_acknowledge;
        logic address_strobe;
        logic chip_select;
        logic interrupt_ack_in;
        logic [2:0] bus_exception_code;
    } dbm_bus_type;

    localparam int BUS_W = $bits(dbm_bus_type);
    localparam logic [BUS_W-1:0] BUS_IDLE_N = {BUS_W{1'b1}};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQUEST = 3'b001,
        ST_WAIT_FREE = 3'b010,
        ST_OWN_ON = 3'b011,
        ST_ACK_ON = 3'b100,
        ST_OWNED = 3'b101,
        ST_RELEASE = 3'b110
    } dbm_state_type;

endpackage : dbm_pkg

// ==== rtl/dbm_sync.sv ====
/*
 * Two flip-flop synchroniser for a vector of asynchronous levels.
 * Assumes each bit is an independent level; no word coherence is given.
 */
module dbm_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta_q <= RESET_VAL;
            o_sync <= RESET_VAL;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule : dbm_sync

// ==== rtl/dbm_arbiter.sv ====
/*
 * Bus mastership handshake of a multi-channel DMA controller: request,
 * take-over, hold and release of the shared bus, plus request recognition.
 * Assumes the transfer engine pulses i_op_done once per started operation
 * and drives the ignore windows; bus pins are asynchronous to i_clk.
 */
// Overview of operation
// - Gain bus ownership before starting any transfer for a pending channel.
// - Assert bus request while a channel is pending and bus is not owned.
// - Take the bus only after strobe and grant acknowledge are both negated.
// - Raise ownership indicator first, grant acknowledge one step later.
// - Drop bus request one clock after grant acknowledge goes active.
// - On finishing, drop grant acknowledge, then ownership indicator one step later.
// - Chip select or interrupt acknowledge while requesting drops bus request until done.
// - First bus cycle starts at least twelve clocks after request recognition.
// - Grant acknowledge may fall together with strobe of the last cycle.
// - Channel operations run strictly one after another while owning the bus.
// - Short request inside an ignore window is not recognised.
// - Request lasting two clocks beyond ignore window is recognised.
// - After halt code clears, wait three clocks before requesting again.
// - Relinquish-retry gives up bus, waits three clocks, reruns same cycle.
module dbm_arbiter
    import dbm_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_bus_grant_in_n,
    input wire logic i_grant_acknowledge_n,
    input wire logic i_address_strobe_n,
    input wire logic i_chip_select_n,
    input wire logic i_interrupt_ack_in_n,
    input wire logic [2:0] i_bus_exception_code_n,
    input wire logic [NUM_CH-1:0] i_channel_transfer_request_n,
    input wire logic [NUM_CH-1:0] i_chan_active,
    input wire logic [NUM_CH-1:0] i_int_request,
    input wire logic [NUM_CH-1:0] i_ignore_window,
    input wire logic i_op_done,
    output logic o_bus_request_out_n,
    output logic o_own_n,
    output logic o_grant_acknowledge_n,
    output logic o_grant_acknowledge_oe,
    output logic o_cycle_go,
    output logic [$clog2(NUM_CH+1)-1:0] o_chan_sel,
    output logic o_rerun
);
    import dbm_pkg::*;

    localparam int SEL_W = $clog2(NUM_CH + 1);

    generate
        if (NUM_CH < 1 || NUM_CH > 8)
        begin : g_bad_param
            $error("NUM_CH must be 1 to 8");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [BUS_W-1:0] bus_raw_n;
    logic [BUS_W-1:0] bus_sync_n;
    logic [NUM_CH-1:0] req_sync_n;
    dbm_bus_type sb;
    logic [NUM_CH-1:0] req_s;

    assign bus_raw_n = {i_bus_grant_in_n, i_grant_acknowledge_n, i_address_strobe_n,
                        i_chip_select_n, i_interrupt_ack_in_n, i_bus_exception_code_n};

    dbm_sync #(.WIDTH(BUS_W), .RESET_VAL(BUS_IDLE_N)) u_bus_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async(bus_raw_n),
        .o_sync(bus_sync_n)
    );

    dbm_sync #(.WIDTH(NUM_CH), .RESET_VAL({NUM_CH{1'b1}})) u_req_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async(i_channel_transfer_request_n),
        .o_sync(req_sync_n)
    );

    assign sb = dbm_bus_type'(~bus_sync_n);
    assign req_s = ~req_sync_n;

    // ----------------------------------------------------------------
    // Exception hold-off and processor deference
    // ----------------------------------------------------------------
    logic [1:0] holdoff_q;
    logic [1:0] holdoff_d;
    logic bec_active;
    logic exc_block;
    logic cpu_block;
    logic halt_code;

    assign bec_active = sb.bus_exception_code != BEC_NORMAL;
    assign halt_code = sb.bus_exception_code == BEC_HALT || sb.bus_exception_code == BEC_RELINQUISH;
    assign cpu_block = sb.chip_select | sb.interrupt_ack_in;
    // Reload while any code is held, count down once it returns to normal
    assign holdoff_d = bec_active ? 2'(REARB_DELAY_CLKS) : (holdoff_q != 2'h0 ? holdoff_q - 2'h1 : 2'h0);
    assign exc_block = bec_active | (holdoff_q != 2'h0);

    // ----------------------------------------------------------------
    // Request recognition, one counter per channel
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0] pending_q;
    logic [NUM_CH-1:0] pending_d;
    logic [NUM_CH-1:0] recognise;
    logic [NUM_CH-1:0] clr;
    logic [SEL_W-1:0] sel_q;
    logic rerun_q;
    logic rerun_d;
    logic busy_q;
    logic retry_end;

    // Taken from the synchronised exception code, not from rerun_d, so the service clear does not loop through go
    assign retry_end = i_op_done && busy_q &&
                       (sb.bus_exception_code == BEC_RETRY || sb.bus_exception_code == BEC_RELINQUISH);

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_chan
            logic [1:0] held_q;
            logic [1:0] held_d;
            logic live;
            assign live = req_s[ch] & ~i_ignore_window[ch];
            // Only time spent outside an ignore window counts toward width
            assign held_d = live ? (held_q == 2'(REQ_MIN_CLKS) ? held_q : held_q + 2'h1) : 2'h0;
            assign recognise[ch] = live && held_q == 2'(REQ_MIN_CLKS - 1);
            assign clr[ch] = i_op_done && busy_q && sel_q == SEL_W'(ch) && !retry_end;
            // Set wins over the service clear
            assign pending_d[ch] = (i_chan_active[ch] & (recognise[ch] | i_int_request[ch])) |
                                   (pending_q[ch] & ~clr[ch]);
            always_ff @(posedge i_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                    held_q <= 2'h0;
                else
                    held_q <= held_d;
            end

            property p_recognise_width;
                @(posedge i_clk) disable iff (!i_nrst)
                recognise[ch] |-> $past(req_s[ch] && !i_ignore_window[ch]);
            endproperty
            a_recognise_width: assert property (p_recognise_width)
                else $error("request recognised before two clean clocks");
        end
    endgenerate

    // Lowest index wins among pending channels
    function automatic logic [SEL_W-1:0] pick_lowest(input logic [NUM_CH-1:0] req);
        logic [SEL_W-1:0] idx;
        idx = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (req[i])
                idx = SEL_W'(i);
        end
        return idx;
    endfunction : pick_lowest

    // ----------------------------------------------------------------
    // Mastership state machine
    // ----------------------------------------------------------------
    dbm_state_type state_q;
    dbm_state_type state_d;
    logic busy_d;
    logic [3:0] fe_cnt_q;
    logic [3:0] fe_cnt_d;
    logic any_pending;
    logic release_now;
    logic go_d;
    logic br_d;
    logic own_d;
    logic gack_d;
    logic [SEL_W-1:0] sel_d;

    assign any_pending = |pending_q;
    // Release with the strobe of the last cycle, or at once if nothing is running
    assign release_now = (i_op_done || !busy_q) && (halt_code || pending_d == '0);
    // Retry keeps pending set and the same channel selected
    assign rerun_d = retry_end ? 1'b1 : (go_d ? 1'b0 : rerun_q);
    assign go_d = state_q == ST_OWNED && !busy_q && !release_now && !exc_block &&
                  fe_cnt_q == 4'h0 && any_pending;
    assign busy_d = go_d | (busy_q & ~i_op_done);
    assign sel_d = go_d ? (rerun_q ? sel_q : pick_lowest(pending_q)) : sel_q;
    assign fe_cnt_d = (state_q == ST_IDLE && state_d == ST_REQUEST) ? 4'(FRONT_MIN_CLKS) :
                      (fe_cnt_q != 4'h0 ? fe_cnt_q - 4'h1 : 4'h0);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
                if (any_pending && !exc_block)
                    state_d = ST_REQUEST;
            ST_REQUEST:
                if (sb.bus_grant_in)
                    state_d = ST_WAIT_FREE;
            ST_WAIT_FREE:
                if (!sb.address_strobe && !sb.grant_acknowledge)
                    state_d = ST_OWN_ON;
            ST_OWN_ON:
                state_d = ST_ACK_ON;
            ST_ACK_ON:
                state_d = ST_OWNED;
            ST_OWNED:
                if (release_now)
                    state_d = ST_RELEASE;
            ST_RELEASE:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    // Processor cycles aimed at us pull the request back without a grant
    assign br_d = ((state_d == ST_REQUEST || state_d == ST_WAIT_FREE) && !cpu_block && !exc_block) ||
                  state_d == ST_OWN_ON || state_d == ST_ACK_ON;
    assign own_d = state_d == ST_OWN_ON || state_d == ST_ACK_ON || state_d == ST_OWNED ||
                   state_d == ST_RELEASE;
    assign gack_d = state_d == ST_ACK_ON || state_d == ST_OWNED;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= ST_IDLE;
            pending_q <= '0;
            busy_q <= 1'b0;
            fe_cnt_q <= 4'h0;
            holdoff_q <= 2'h0;
            sel_q <= '0;
            rerun_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pending_q <= pending_d;
            busy_q <= busy_d;
            fe_cnt_q <= fe_cnt_d;
            holdoff_q <= holdoff_d;
            sel_q <= sel_d;
            rerun_q <= rerun_d;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_bus_request_out_n <= 1'b1;
            o_own_n <= 1'b1;
            o_grant_acknowledge_n <= 1'b1;
            o_grant_acknowledge_oe <= 1'b0;
            o_cycle_go <= 1'b0;
            o_chan_sel <= '0;
            o_rerun <= 1'b0;
        end
        else
        begin
            o_bus_request_out_n <= ~br_d;
            o_own_n <= ~own_d;
            o_grant_acknowledge_n <= ~gack_d;
            o_grant_acknowledge_oe <= gack_d;
            o_cycle_go <= go_d;
            o_chan_sel <= sel_d;
            o_rerun <= rerun_q & go_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [3:0] since_req_q;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            since_req_q <= 4'h0;
        else if (state_q == ST_IDLE)
            since_req_q <= 4'h0;
        else if (since_req_q != 4'hf)
            since_req_q <= since_req_q + 4'h1;
    end

    property p_go_owned;
        @(posedge i_clk) disable iff (!i_nrst)
        o_cycle_go |-> !o_own_n && !o_grant_acknowledge_n;
    endproperty
    a_go_owned: assert property (p_go_owned)
        else $error("cycle started without bus ownership");

    property p_br_pending;
        @(posedge i_clk) disable iff (!i_nrst)
        (state_q == ST_IDLE && any_pending && !exc_block && !cpu_block) |=> !o_bus_request_out_n;
    endproperty
    a_br_pending: assert property (p_br_pending)
        else $error("bus request missing while a channel is pending");

    property p_take_free;
        @(posedge i_clk) disable iff (!i_nrst)
        $fell(o_own_n) |-> $past(!sb.address_strobe && !sb.grant_acknowledge && state_q == ST_WAIT_FREE);
    endproperty
    a_take_free: assert property (p_take_free)
        else $error("bus taken while strobe or acknowledge still active");

    property p_own_then_ack;
        @(posedge i_clk) disable iff (!i_nrst)
        $fell(o_own_n) |-> o_grant_acknowledge_n ##1 $fell(o_grant_acknowledge_n) && o_grant_acknowledge_oe;
    endproperty
    a_own_then_ack: assert property (p_own_then_ack)
        else $error("grant acknowledge not one step after ownership");

    property p_br_drop;
        @(posedge i_clk) disable iff (!i_nrst)
        $fell(o_grant_acknowledge_n) |=> o_bus_request_out_n;
    endproperty
    a_br_drop: assert property (p_br_drop)
        else $error("bus request not dropped one clock after acknowledge");

    property p_release_order;
        @(posedge i_clk) disable iff (!i_nrst)
        $rose(o_grant_acknowledge_n) |-> !o_own_n ##1 o_own_n;
    endproperty
    a_release_order: assert property (p_release_order)
        else $error("ownership not released one step after acknowledge");

    property p_cpu_defer;
        @(posedge i_clk) disable iff (!i_nrst)
        (cpu_block && (state_q == ST_REQUEST || state_q == ST_WAIT_FREE) &&
         (state_d == ST_REQUEST || state_d == ST_WAIT_FREE)) |=> o_bus_request_out_n;
    endproperty
    a_cpu_defer: assert property (p_cpu_defer)
        else $error("bus request held during processor access");

    property p_front_end;
        @(posedge i_clk) disable iff (!i_nrst)
        o_cycle_go |-> since_req_q > 4'(FRONT_MIN_CLKS);
    endproperty
    a_front_end: assert property (p_front_end)
        else $error("first cycle started too soon after request");

    property p_serial;
        @(posedge i_clk) disable iff (!i_nrst)
        o_cycle_go |=> !o_cycle_go throughout (busy_q [*1]);
    endproperty
    a_serial: assert property (p_serial)
        else $error("channel operations overlapped");

    property p_rearb_wait;
        @(posedge i_clk) disable iff (!i_nrst)
        ($past(bec_active) && !bec_active) |-> o_bus_request_out_n [*3];
    endproperty
    a_rearb_wait: assert property (p_rearb_wait)
        else $error("bus requested within three clocks of exception clearing");

    property p_hold_ack;
        @(posedge i_clk) disable iff (!i_nrst)
        (state_q == ST_OWNED && !release_now) |=> !o_grant_acknowledge_n;
    endproperty
    a_hold_ack: assert property (p_hold_ack)
        else $error("grant acknowledge dropped with work pending");

    c_take_bus: cover property (@(posedge i_clk) disable iff (!i_nrst) $fell(o_grant_acknowledge_n));
    c_cpu_defer: cover property (@(posedge i_clk) disable iff (!i_nrst)
        state_q == ST_REQUEST && cpu_block);
    c_rerun: cover property (@(posedge i_clk) disable iff (!i_nrst) o_rerun);
    c_back_to_back: cover property (@(posedge i_clk) disable iff (!i_nrst)
        o_cycle_go ##[1:50] o_cycle_go);

endmodule : dbm_arbiter

// ==== tb/dbm_bus_model.sv ====
/*
 * Far side of the bus mastership block: an external arbiter and a host
 * processor that runs bus cycles of its own while it holds the bus.
 * Assumes the bench resolves the grant acknowledge wire with a pull-up.
 */
module dbm_bus_model (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_bus_request_out_n,
    input wire logic i_grant_acknowledge_n,
    input wire logic i_slow,
    output logic o_bus_grant_in_n,
    output logic o_address_strobe_n
);
    timeunit 1ns;
    timeprecision 100ps;

    int gcnt;
    int pcnt;
    int free_cnt;
    logic busy;

    // ----------------------------------------------------------------
    // Arbiter and host cycles
    // ----------------------------------------------------------------
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            gcnt <= 0;
            pcnt <= 0;
            free_cnt <= 0;
            busy <= 1'b0;
            o_bus_grant_in_n <= 1'b1;
        end
        else
        begin
            // Slow grants leave room for a processor access to cut in
            gcnt <= i_bus_request_out_n ? 0 : gcnt + 1;
            o_bus_grant_in_n <= i_bus_request_out_n || gcnt < (i_slow ? 20 : 2);
            free_cnt <= i_grant_acknowledge_n ? free_cnt + 1 : 0;
            if (busy)
            begin
                pcnt <= pcnt + 1;
                busy <= pcnt != 5;
            end
            else if (o_bus_grant_in_n && free_cnt >= 2)
            begin
                pcnt <= 0;
                busy <= 1'b1;
            end
        end
    end

    assign o_address_strobe_n = !(busy && pcnt < 4);

endmodule : dbm_bus_model

// ==== tb/testbench.sv ====
/*
 * Self-checking bench of the bus mastership block: raises channel requests,
 * plays the transfer engine and checks the handshake seen at the pins.
 * Assumes dbm_bus_model as far side and a 50 MHz clock.
 */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dbm_pkg::*;

    typedef struct packed {
        logic [2:0] chan;
        logic rerun;
    } dbm_note_type;

    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic cs_n = 1'b1;
    logic interrupt_ack_in_n = 1'b1;
    logic [2:0] bec_n = 3'h7;
    logic [3:0] dreq_n = 4'hf;
    logic [3:0] active = 4'hf;
    logic [3:0] int_req = 4'h0;
    logic [3:0] window = 4'h0;
    logic op_done = 1'b0;
    logic eng_as_n = 1'b1;
    logic slow = 1'b0;
    logic chk_hold = 1'b0;
    logic [2:0] exc_code = 3'h0;
    logic [2:0] code;
    logic [7:0] lfsr = 8'h2b;
    logic [2:0] as_hist = 3'h7;
    logic prev_req = 1'b1;
    logic prev_own = 1'b1;
    logic prev_gack = 1'b1;
    logic grant_n, host_as_n, req_n, own_n, gack_n, gack_oe, go, rerun;
    logic [2:0] sel;
    int cyc = 0;
    int t_req = 0;
    int t_gack = 0;
    int t_rel = 0;
    int mismatches = 0;
    int cmp_count = 0;
    dbm_note_type note;
    dbm_note_type exp_q[$];

    // Grant acknowledge is pulled up whenever nobody drives it
    wire gack_wire = gack_oe ? gack_n : 1'b1;
    wire as_wire = host_as_n & eng_as_n;

    dbm_arbiter #(.NUM_CH(4)) dbm_arbiter_inst (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_bus_grant_in_n(grant_n),
        .i_grant_acknowledge_n(gack_wire), .i_address_strobe_n(as_wire),
        .i_chip_select_n(cs_n), .i_interrupt_ack_in_n(interrupt_ack_in_n), .i_bus_exception_code_n(bec_n),
        .i_channel_transfer_request_n(dreq_n), .i_chan_active(active), .i_int_request(int_req),
        .i_ignore_window(window), .i_op_done(op_done), .o_bus_request_out_n(req_n),
        .o_own_n(own_n), .o_grant_acknowledge_n(gack_n), .o_grant_acknowledge_oe(gack_oe),
        .o_cycle_go(go), .o_chan_sel(sel), .o_rerun(rerun));

    dbm_bus_model dbm_bus_model_inst (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_bus_request_out_n(req_n),
        .i_grant_acknowledge_n(gack_wire), .i_slow(slow),
        .o_bus_grant_in_n(grant_n), .o_address_strobe_n(host_as_n));

    initial forever #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : tick

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        cmp_count++;
        if (seen !== expv)
        begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, expv, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic request(input logic [3:0] mask);
        for (int c = 0; c < 4; c++)
            if (mask[c])
                exp_q.push_back(dbm_note_type'{c[2:0], 1'b0});
        int_req = mask;
        tick(1);
        int_req = 4'h0;
    endtask : request

    task automatic drain();
        for (int i = 0; i < 600 && (exp_q.size() != 0 || own_n !== 1'b1); i++)
            tick(1);
        check("drained", exp_q.size(), 0);
        tick(3);
    endtask : drain

    // ----------------------------------------------------------------
    // Transfer engine: one strobed operation per go
    // ----------------------------------------------------------------
    always @(negedge i_clk)
    begin
        if (i_nrst && go === 1'b1)
        begin
            tick(1);
            eng_as_n = 1'b0;
            if (exc_code != 3'h0)
                bec_n = ~exc_code;
            exc_code = 3'h0;
            tick(4);
            eng_as_n = 1'b1;
            op_done = 1'b1;
            tick(1);
            op_done = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Output watcher
    // ----------------------------------------------------------------
    always @(negedge i_clk)
    begin
        cyc++;
        if (i_nrst)
        begin
            if (go)
            begin
                check("owned_at_go", {own_n, gack_oe}, 2'b01);
                check("front_gap", cyc - t_req >= 13, 1);
                if (exp_q.size() == 0)
                    check("go_count", 1, 0);
                else
                begin
                    note = exp_q.pop_front();
                    check("chan_sel", {sel, rerun}, note);
                end
            end
            if (prev_req && !req_n)
                t_req = cyc;
            if (prev_own && !own_n)
                check("strobe_free", as_hist[2], 1);
            if (prev_gack && !gack_n)
            begin
                t_gack = cyc;
                check("own_first", prev_own, 0);
            end
            if (!prev_req && req_n && !own_n)
                check("req_drop_gap", cyc - t_gack, 1);
            if (!prev_gack && gack_n)
            begin
                t_rel = cyc;
                check("ack_held", chk_hold && exp_q.size() != 0, 0);
                check("ack_with_strobe", as_hist[1:0], 2'b01);
            end
            if (!prev_own && own_n)
                check("own_last", cyc - t_rel, 1);
        end
        prev_req = req_n;
        prev_own = own_n;
        prev_gack = gack_n;
        as_hist = {as_hist[1:0], as_wire};
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        tick(3);
        check("reset_out", {req_n, own_n, gack_n, gack_oe, go, sel, rerun}, {4'he, 1'b0, 3'h0, 1'b0});
        i_nrst = 1'b1;
        chk_hold = 1'b1;
        for (int r = 0; r < 6; r++)
        begin
            lfsr = lfsr_next(lfsr);
            slow = lfsr[4];
            request((lfsr[3:0] == 4'h0) ? 4'h1 : lfsr[3:0]);
            drain();
        end
        chk_hold = 1'b0;
        $display("test arbitration done");
        for (int k = 0; k < 2; k++)
        begin
            slow = 1'b1;
            request(4'h4);
            for (int i = 0; i < 10 && req_n !== 1'b0; i++)
                tick(1);
            {cs_n, interrupt_ack_in_n} = k ? 2'b10 : 2'b01;
            tick(4);
            check("req_yields", req_n, 1);
            {cs_n, interrupt_ack_in_n} = 2'b11;
            tick(6);
            check("req_again", req_n, 0);
            drain();
        end
        slow = 1'b0;
        active = 4'h7;
        int_req = 4'h8;
        tick(1);
        int_req = 4'h0;
        tick(8);
        check("inactive_idle", req_n, 1);
        active = 4'hf;
        window = 4'h8;
        dreq_n = 4'h7;
        tick(3);
        dreq_n = 4'hf;
        tick(4);
        window = 4'h0;
        tick(8);
        check("short_ignored", req_n, 1);
        window = 4'h8;
        exp_q.push_back(dbm_note_type'{3'h3, 1'b0});
        dreq_n = 4'h7;
        tick(3);
        window = 4'h0;
        tick(5);
        dreq_n = 4'hf;
        drain();
        $display("test request handling done");
        for (int k = 0; k < 3; k++)
        begin
            code = (k == 0) ? BEC_HALT : ((k == 1) ? BEC_RETRY : BEC_RELINQUISH);
            exc_code = code;
            // Halt leaves a second channel pending so that re-arbitration is really exercised
            request(code == BEC_HALT ? 4'h6 : 4'h2);
            if (code != BEC_HALT)
                exp_q.push_back(dbm_note_type'{3'h1, 1'b1});
            for (int i = 0; i < 100 && go !== 1'b1; i++)
                tick(1);
            tick(10);
            check("bus_kept", gack_oe, code == BEC_RETRY);
            check("no_request", req_n, 1);
            bec_n = 3'h7;
            tick(4);
            check("rearb_delay", req_n, 1);
            drain();
        end
        $display("test exceptions done");
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        give_verdict();
    end

endmodule : testbench
